// ---- rtl/ccs_map.svh ----
// named offsets, codes, bit positions and reset values of the coefficient words
// assumes inclusion from the ccs design module and the ccs bench
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CCS_CMD_WR_FIRST 8'h40
`define CCS_CMD_WR_LAST 8'h57
`define CCS_CMD_PAGE_INC 8'h5E

// ----------------------------------------------------------------
// word addresses and pages
// ----------------------------------------------------------------
`define CCS_ADDR_BRIDGE 8'h03
`define CCS_ADDR_TEMP 8'h04
`define CCS_PAGE_FIRST 2'h0
`define CCS_PAGE_LAST 2'h3
`define CCS_WORD_RESET 16'h0000
`define CCS_TEMP_USED_MASK 16'h003F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCS_NUM_COEF 10
`define CCS_NUM_BRIDGE_COEF 7
`define CCS_BIT_CURVE 14
`define CCS_BIT_SETTL 15

`endif

// ---- rtl/ccs_pkg.sv ----
// types shared by the coefficient top-bit and sign word bank
// assumes ccs_map.svh is on the include path
`default_nettype none

package ccs_pkg;

  // one sign-magnitude coefficient
  typedef struct packed {
    logic negative;
    logic [16:0] magnitude;
  } ccs_coef_t;

  // one command from the serial command decoder
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] data;
  } ccs_cmd_t;

  typedef enum logic [1:0] {
    CCS_KIND_NONE,
    CCS_KIND_WRITE,
    CCS_KIND_PAGE,
    CCS_KIND_OTHER
  } ccs_kind_t;

endpackage

`default_nettype wire

// ---- rtl/ccs_coef_words.sv ----
// top-bit and sign words of the calibration coefficients, page handling
// assumes commands come from the serial decoder on clk, low words from memory
//
// Overview of operation
// RULE1: bridge word bit 0 is offset bit 16, joined with word 05h low bits.
// RULE2: each stored sign 0 means positive, 1 means negative magnitude.
// RULE3: bridge bit 2 is gain bit 16 with word 06h; bit 3 gain sign.
// RULE4: bridge bit 4 is first-order gain drift bit 16 with 07h; bit 5 sign.
// RULE5: bridge bit 6 is first-order offset drift bit 16 with 08h; bit 7 sign.
// RULE6: bits 8/9 second-order offset drift, bits 10/11 second-order gain drift.
// RULE7: bridge bit 12 is second-order bridge bit 16 with 0Bh; bit 13 sign.
// RULE8: bridge bit 14 picks curve: 0 parabolic, 1 S-shaped.
// RULE9: bridge bit 15 is the settling term sign, 1 negative.
// RULE10: temperature bit 0 is sensor gain bit 16 with 0Dh; bit 1 sign.
// RULE11: temperature bit 2 is sensor second-order bit 16 with 0Eh; bit 3 sign.
// RULE12: temperature bit 4 is sensor offset bit 16 with 0Ch; bits 15:6 unused.
// RULE13: words are written only by memory write codes 40h to 57h.
// RULE14: one write per word per page; four pages; page step clears words.
// RULE15: all bits read zero until programmed.
`include "ccs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ccs_coef_words
  import ccs_pkg::*;
#(
  parameter int NUM_COEF = `CCS_NUM_COEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command port
  input wire ccs_cmd_t cmd,
  // low sixteen bits, index order: 05h..0Bh, 0Dh, 0Eh, 0Ch
  input wire logic [15:0] low_word [NUM_COEF],
  // readback and page state
  output logic [15:0] bridge_word_reg,
  output logic [15:0] temp_word_reg,
  output logic [1:0] page_reg,
  output logic pages_used_up_reg,
  output logic wr_done_reg,
  output logic wr_refused_reg,
  // decoded coefficients, index order as low_word
  output ccs_coef_t coef_reg [NUM_COEF],
  output logic curve_s_shaped_reg,
  output logic settling_term_negative_reg
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic ccs_kind_t cmd_kind(input ccs_cmd_t c);
    if (!c.valid) begin
      return CCS_KIND_NONE;
    end else if (c.code >= `CCS_CMD_WR_FIRST && c.code <= `CCS_CMD_WR_LAST)
    begin
      return CCS_KIND_WRITE;
    end else if (c.code == `CCS_CMD_PAGE_INC) begin
      return CCS_KIND_PAGE;
    end
    return CCS_KIND_OTHER;
  endfunction

  // top bit and sign of coefficient i
  function automatic logic [1:0] coef_hi(input int i, // RULE7 RULE11
      input logic [15:0] bw, input logic [15:0] tw);
    int b;
    b = 0;
    if (i < `CCS_NUM_BRIDGE_COEF) begin
      b = 2 * i;
      return {bw[b+1], bw[b]};
    end
    b = 2 * (i - `CCS_NUM_BRIDGE_COEF);
    return {tw[b+1], tw[b]};
  endfunction

  // ----------------------------------------------------------------
  // word and page state
  // ----------------------------------------------------------------
  logic [15:0] bridge_word_next;
  logic [15:0] temp_word_next;
  logic [1:0] page_next;
  logic bridge_prog_reg, bridge_prog_next;
  logic temp_prog_reg, temp_prog_next;
  logic wr_done_next, wr_refused_next;
  logic [7:0] wr_addr;
  ccs_kind_t kind;

  always_comb begin
    kind = cmd_kind(cmd);
    wr_addr = cmd.code - `CCS_CMD_WR_FIRST;
    bridge_word_next = bridge_word_reg;
    temp_word_next = temp_word_reg;
    page_next = page_reg;
    bridge_prog_next = bridge_prog_reg;
    temp_prog_next = temp_prog_reg;
    wr_done_next = 1'b0;
    wr_refused_next = 1'b0;
    case (kind)
      CCS_KIND_WRITE: begin
        if (wr_addr == `CCS_ADDR_BRIDGE) begin
          if (bridge_prog_reg) begin
            wr_refused_next = 1'b1; // RULE14
          end else begin
            bridge_word_next = cmd.data; // RULE13
            bridge_prog_next = 1'b1;
            wr_done_next = 1'b1;
          end
        end else if (wr_addr == `CCS_ADDR_TEMP) begin
          if (temp_prog_reg) begin
            wr_refused_next = 1'b1; // RULE14
          end else begin
            temp_word_next = cmd.data & `CCS_TEMP_USED_MASK; // RULE12
            temp_prog_next = 1'b1;
            wr_done_next = 1'b1;
          end
        end
      end
      CCS_KIND_PAGE: begin
        if (page_reg != `CCS_PAGE_LAST) begin
          page_next = page_reg + 2'h1; // RULE14
          bridge_word_next = `CCS_WORD_RESET;
          temp_word_next = `CCS_WORD_RESET;
          bridge_prog_next = 1'b0;
          temp_prog_next = 1'b0;
        end else begin
          wr_refused_next = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bridge_word_reg <= `CCS_WORD_RESET; // RULE15
      temp_word_reg <= `CCS_WORD_RESET;
      page_reg <= `CCS_PAGE_FIRST;
      bridge_prog_reg <= 1'b0;
      temp_prog_reg <= 1'b0;
      wr_done_reg <= 1'b0;
      wr_refused_reg <= 1'b0;
      pages_used_up_reg <= 1'b0;
    end else begin
      bridge_word_reg <= bridge_word_next;
      temp_word_reg <= temp_word_next;
      page_reg <= page_next;
      bridge_prog_reg <= bridge_prog_next;
      temp_prog_reg <= temp_prog_next;
      wr_done_reg <= wr_done_next;
      wr_refused_reg <= wr_refused_next;
      pages_used_up_reg <= (page_next == `CCS_PAGE_LAST);
    end
  end

  // ----------------------------------------------------------------
  // coefficient assembly
  // ----------------------------------------------------------------
  ccs_coef_t coef_next [NUM_COEF];
  logic curve_next, settl_next;

  for (genvar g = 0; g < NUM_COEF; g++) begin : g_coef
    logic [1:0] hi;
    always_comb begin
      hi = coef_hi(g, bridge_word_reg, temp_word_reg); // RULE4 RULE5 RULE6
      coef_next[g].magnitude = {hi[0], low_word[g]}; // RULE1 RULE3 RULE10
      coef_next[g].negative = hi[1]; // RULE2
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        coef_reg[g] <= '0; // RULE15
      end else begin
        coef_reg[g] <= coef_next[g];
      end
    end
  end

  always_comb begin
    curve_next = bridge_word_reg[`CCS_BIT_CURVE]; // RULE8
    settl_next = bridge_word_reg[`CCS_BIT_SETTL]; // RULE9
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      curve_s_shaped_reg <= 1'b0;
      settling_term_negative_reg <= 1'b0;
    end else begin
      curve_s_shaped_reg <= curve_next;
      settling_term_negative_reg <= settl_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic past_ok;
  always_ff @(posedge clk) begin
    if (rst) begin
      past_ok <= 1'b0;
    end else begin
      past_ok <= 1'b1;
    end
  end

  chk_offset_top_bit: assert property ( // RULE1
    past_ok |-> coef_reg[0].magnitude ==
      {$past(bridge_word_reg[0]), $past(low_word[0])})
    else $error("offset top bit wrong");
  chk_sign_decode: assert property ( // RULE2
    past_ok |-> coef_reg[0].negative == $past(bridge_word_reg[1]))
    else $error("offset sign wrong");
  chk_gain_bits: assert property ( // RULE3
    past_ok |-> {coef_reg[1].negative, coef_reg[1].magnitude[16]} ==
      $past(bridge_word_reg[3:2]))
    else $error("gain bits wrong");
  chk_drift_first: assert property ( // RULE4
    past_ok |-> {coef_reg[2].negative, coef_reg[3].negative} ==
      {$past(bridge_word_reg[5]), $past(bridge_word_reg[7])})
    else $error("first-order drift signs wrong");
  chk_drift_tops: assert property ( // RULE5
    past_ok |-> {coef_reg[3].magnitude[16], coef_reg[2].magnitude[16]} ==
      {$past(bridge_word_reg[6]), $past(bridge_word_reg[4])})
    else $error("first-order drift top bits wrong");
  chk_sensor_gain: assert property ( // RULE10
    past_ok |-> {coef_reg[7].negative, coef_reg[7].magnitude[16]} ==
      $past(temp_word_reg[1:0]))
    else $error("sensor gain bits wrong");
  chk_drift_second: assert property ( // RULE6
    past_ok |-> {coef_reg[5].negative, coef_reg[5].magnitude[16],
      coef_reg[4].negative, coef_reg[4].magnitude[16]} ==
      $past(bridge_word_reg[11:8]))
    else $error("second-order drift bits wrong");
  chk_bridge_second: assert property ( // RULE7
    past_ok |-> coef_reg[6].magnitude[16] == $past(bridge_word_reg[12]))
    else $error("second-order bridge bit wrong");
  chk_curve_shape: assert property ( // RULE8
    $rose(bridge_word_reg[14]) |=> curve_s_shaped_reg)
    else $error("curve select not followed");
  chk_settl_sign: assert property ( // RULE9
    $fell(bridge_word_reg[15]) |=> !settling_term_negative_reg)
    else $error("settling sign not followed");
  chk_temp_bits: assert property ( // RULE11
    past_ok |-> {coef_reg[9].magnitude[16], coef_reg[8].magnitude[16],
      coef_reg[7].magnitude[16]} == {$past(temp_word_reg[4]),
      $past(temp_word_reg[2]), $past(temp_word_reg[0])})
    else $error("temperature top bits wrong");
  chk_temp_unused: assert property ( // RULE12
    temp_word_reg[15:6] == 10'h000)
    else $error("unassigned temperature bits set");
  chk_write_only_cmd: assert property ( // RULE13
    kind == CCS_KIND_OTHER || kind == CCS_KIND_NONE |=>
      $stable(bridge_word_reg) && $stable(temp_word_reg))
    else $error("word changed without write");
  chk_once_per_page: assert property ( // RULE14
    kind == CCS_KIND_WRITE && wr_addr == `CCS_ADDR_BRIDGE &&
      bridge_prog_reg |=> $stable(bridge_word_reg) && wr_refused_reg)
    else $error("second write in page accepted");
  chk_page_step: assert property ( // RULE14
    kind == CCS_KIND_PAGE && page_reg != `CCS_PAGE_LAST |=>
      page_reg == $past(page_reg) + 2'h1 && bridge_word_reg == 16'h0000)
    else $error("page step wrong");
  chk_reset_zero: assert property (disable iff (1'b0) // RULE15
    rst |=> bridge_word_reg == 16'h0000 && temp_word_reg == 16'h0000)
    else $error("words not zero after reset");

endmodule

`default_nettype wire

// ---- bench/ccs_coef_words_tb.sv ----
// bench for the coefficient top-bit and sign word bank
// assumes ccs_pkg and ccs_map.svh compiled and on the include path
`include "ccs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ccs_coef_words_tb;
  import ccs_pkg::*;

  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] b;
    logic [15:0] t;
    logic [1:0] pg;
  } ccs_note_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  ccs_cmd_t cmd;
  logic [15:0] low_word [10];
  logic [15:0] bw, tw;
  logic [1:0] pg;
  logic used, done, refd, curve, settl;
  ccs_coef_t coef [10];
  ccs_note_t notes [$];
  int err_total, n_checks, seed;
  logic [15:0] mb, mt, eb, et, cb, ct;
  logic [1:0] mpg, ppg;
  logic pb, pt;

  ccs_coef_words u_ccs_coef_words (.clk(clk), .rst(rst), .cmd(cmd),
    .low_word(low_word), .bridge_word_reg(bw), .temp_word_reg(tw),
    .page_reg(pg), .pages_used_up_reg(used), .wr_done_reg(done),
    .wr_refused_reg(refd), .coef_reg(coef), .curve_s_shaped_reg(curve),
    .settling_term_negative_reg(settl));

  initial begin
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    for (int i = 0; i < 10; i++) low_word[i] <= 16'($urandom);
  end

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_stat(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_coef(input int i, input ccs_coef_t e, input ccs_coef_t g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD coef %0d exp %h got %h", i, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // driver with its own model of the words
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    logic [1:0] k;
    @(negedge clk);
    cmd = '{1'b1, code, data};
    k = 2'h0;
    if (code == 8'h43) begin
      if (pb) k = 2'h2;
      else begin
        k = 2'h1;
        pb = 1'b1;
        mb = data;
      end
    end else if (code == 8'h44) begin
      if (pt) k = 2'h2;
      else begin
        k = 2'h1;
        pt = 1'b1;
        mt = data & `CCS_TEMP_USED_MASK;
      end
    end else if (code == `CCS_CMD_PAGE_INC) begin
      if (mpg == 2'h3) k = 2'h2;
      else begin
        k = 2'h3;
        mpg++;
        {mb, mt, pb, pt} = '0;
      end
    end
    if (k != 2'h0) notes.push_back('{k, mb, mt, mpg});
  endtask

  // ----------------------------------------------------------------
  // monitor: status against notes, coefficients against word model
  // ----------------------------------------------------------------
  initial begin
    ccs_coef_t ec;
    ccs_note_t n;
    repeat (17) @(posedge clk);
    forever begin
      #1;
      for (int i = 0; i < 10; i++) begin
        if (i < 7) ec = '{cb[2*i+1], {cb[2*i], low_word[i]}};
        else ec = '{ct[2*i-13], {ct[2*i-14], low_word[i]}};
        chk_coef(i, ec, coef[i]);
      end
      chk_stat("curve", 16'(cb[14]), 16'(curve));
      chk_stat("settle", 16'(cb[15]), 16'(settl));
      if (done === 1'b1 || refd === 1'b1 || pg !== ppg) begin
        if (notes.size() == 0) chk_stat("note", 16'h0000, 16'h0001);
        else begin
          n = notes.pop_front();
          chk_stat("done", 16'(n.kind == 2'h1), 16'(done));
          if (n.kind != 2'h3)
            chk_stat("refused", 16'(n.kind == 2'h2), 16'(refd));
          chk_stat("page", 16'(n.pg), 16'(pg));
          chk_stat("used", 16'(n.pg == 2'h3), 16'(used));
          chk_stat("bridge", n.b, bw);
          chk_stat("temp", n.t, tw);
          eb = n.b;
          et = n.t;
        end
      end
      ppg = pg;
      cb = eb;
      ct = et;
      @(posedge clk);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cmd = '0;
    for (int i = 0; i < 10; i++) low_word[i] = 16'h0000;
    {err_total, n_checks} = '0;
    {mb, mt, eb, et, cb, ct, mpg, ppg, pb, pt} = '0;
    seed = $urandom(32'h3a44);
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_stat("bridge", `CCS_WORD_RESET, bw);
    chk_stat("temp", `CCS_WORD_RESET, tw);
    chk_stat("page", 16'h0000, 16'(pg));
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      send(8'h43, p == 0 ? 16'hFFFF : 16'($urandom));
      send(8'h44, p == 0 ? 16'hFFFF : 16'($urandom));
      send(8'h43, 16'($urandom));
      send(8'h44, 16'($urandom));
      send(8'h45, 16'($urandom));
      send(8'h58, 16'($urandom));
      send(8'h3F, 16'($urandom));
      @(negedge clk) cmd.valid = 1'b0;
      repeat (3) @(negedge clk);
      send(`CCS_CMD_PAGE_INC, 16'h0000);
      @(negedge clk) cmd.valid = 1'b0;
      repeat (3) @(negedge clk);
      $display("test page %0d done", p);
    end
    for (int w = 0; w < 20 && notes.size() > 0; w++) @(negedge clk);
    if (notes.size() > 0) chk_stat("drain", 16'h0000, 16'(notes.size()));
    stop_test();
  end
endmodule

`default_nettype wire
